/* File: verilog/cfm_cfg.svh */
// Constants of the clock supervisor: counts, field codes and reset values.
// Assumes inclusion by every design file that needs these numbers.
`ifndef CFM_CFG_SVH
`define CFM_CFG_SVH

// Failure watch: reference cycles without a watched edge
`define CFM_FAIL_LIMIT       6'h20
`define CFM_FAIL_CNT_W       6

// Frequency window check widths
`define CFM_COUNT_W          16
`define CFM_DIV_W            10

// Count-cycle field codes and reset value
`define CFM_CCS_DIV256       3'h5
`define CFM_CCS_DIV512       3'h6
`define CFM_CCS_DIV1024      3'h7
`define CFM_CCS_RESET        3'h7

// Divider bit that gives each ratio
`define CFM_DIV256_BIT       7
`define CFM_DIV512_BIT       8
`define CFM_DIV1024_BIT      9

// Window and captured count reset values
`define CFM_UPPER_RESET      16'hFFFF
`define CFM_LOWER_RESET      16'h0000
`define CFM_CAPTURE_RESET    16'h0000

`endif

/* File: verilog/cfm_pkg.sv */
// Types shared by the clock supervisor design files.
// Assumes nothing beyond a SystemVerilog compiler.
package cfm_pkg;

  // Frequency window check sequencing
  typedef enum logic [1:0] {
    cfm_fs_idle    = 2'b00,
    cfm_fs_arm     = 2'b01,
    cfm_fs_measure = 2'b10
  } cfm_freq_state_type;

endpackage

/* File: verilog/cfm_sync.sv */
// Two-stage synchroniser with a rising-edge pulse for each bit.
// Assumes inputs are asynchronous pins; rise pulses last one mclk cycle.
module cfm_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out,
  output logic      [WIDTH-1:0] rise
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // ----------------------------------------
  // Sampling chain
  // ----------------------------------------
  // Stage1 is read only by stage2 to keep metastability contained
  always_ff @(posedge mclk) begin
    if (rst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  assign sync_out = stage2;
  assign rise     = stage2 & ~stage3;

endmodule

/* File: verilog/cfm_fail_watch.sv */
// One clock failure watch: counts reference edges between watched edges.
// Assumes edge pulses are one mclk cycle wide and already synchronised.
`include "cfm_cfg.svh"
module cfm_fail_watch (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic active,
  input  wire logic ref_edge,
  input  wire logic watch_edge,
  output logic      fail
);

  logic [`CFM_FAIL_CNT_W-1:0] gap_count;
  logic [`CFM_FAIL_CNT_W-1:0] next_gap_count;
  logic                       next_fail;

  // ----------------------------------------
  // Gap counter
  // ----------------------------------------
  // A watched edge restarts the gap; inactive watch holds it at zero
  always_comb begin
    next_gap_count = gap_count;
    next_fail      = 1'b0;
    if (!active || watch_edge) begin
      next_gap_count = '0;
    end else if (ref_edge) begin
      if (gap_count == `CFM_FAIL_LIMIT - 6'h01) begin
        next_fail      = 1'b1;
        next_gap_count = '0;
      end else begin
        next_gap_count = gap_count + 6'h01;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      gap_count <= '0;
      fail      <= 1'b0;
    end else begin
      gap_count <= next_gap_count;
      fail      <= next_fail;
    end
  end

endmodule

/* File: verilog/cfm_top.sv */
// Clock supervisor: main/sub clock failure watch and main clock window check.
// Assumes oscillator and clock pins are asynchronous to mclk; control and
// status levels come from logic on mclk. Reset requests hold until rst.
//
// Function
// - Main clock missing for 32 high-speed CR cycles requests system reset.
// - Sub clock missing for 32 low-speed CR cycles requests system reset.
// - Main and sub failure watches run independently of each other.
// - Failure watch pauses while oscillators stopped or stabilising.
// - Failure watch resumes on its own once stabilisation ends.
// - Separate main and sub enables; a disabled watch never requests reset.
// - Count main-clock cycles between rising edges of divided high-speed CR.
// - Codes 101/110/111 divide by 256/512/1024; resets to 111.
// - Count within lower..upper inclusive is a normal frequency.
// - Count outside the window flags error and raises interrupt request.
// - With reset enabled, repeat error while interrupt pending requests reset.
// - With reset disabled, repeated errors give only interrupt requests.
// - Out-of-window count is latched into the captured count register.
// - Window check watches main clock; pauses while it stops or stabilises.
// - Window check starts only when software sets its enable.
`include "cfm_cfg.svh"
module cfm_top
  import cfm_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire logic                    main_clk_pin,
  input  wire logic                    sub_clk_pin,
  input  wire logic                    hcr_clk_pin,
  input  wire logic                    lcr_clk_pin,
  input  wire logic                    main_osc_ready,
  input  wire logic                    sub_osc_ready,
  input  wire logic                    main_fail_monitor_enable,
  input  wire logic                    sub_fail_monitor_enable,
  input  wire logic                    freq_check_enable,
  input  wire logic                    freq_reset_enable,
  input  wire logic [2:0]              count_cycle_select,
  input  wire logic [`CFM_COUNT_W-1:0] window_upper_reg,
  input  wire logic [`CFM_COUNT_W-1:0] window_lower_reg,
  input  wire logic                    fail_flag_clear,
  input  wire logic                    freq_irq_clear,
  output logic                         main_fail_flag,
  output logic                         sub_fail_flag,
  output logic                         fail_reset_req,
  output logic                         freq_irq_req,
  output logic                         freq_reset_req,
  output logic [`CFM_COUNT_W-1:0]      captured_count_reg,
  output logic [`CFM_COUNT_W-1:0]      live_count
);

  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------
  logic [3:0] pin_sync;
  logic [3:0] pin_rise;
  logic       main_edge;
  logic       sub_edge;
  logic       hcr_edge;
  logic       lcr_edge;

  // All four clocks are sampled; mclk must be well above each of them
  cfm_sync #(
    .WIDTH (4)
  ) u_sync (
    .mclk     (mclk),
    .rst      (rst),
    .async_in ({lcr_clk_pin, hcr_clk_pin, sub_clk_pin, main_clk_pin}),
    .sync_out (pin_sync),
    .rise     (pin_rise)
  );

  assign main_edge = pin_rise[0];
  assign sub_edge  = pin_rise[1];
  assign hcr_edge  = pin_rise[2];
  assign lcr_edge  = pin_rise[3];

  // ----------------------------------------
  // Clock failure watches
  // ----------------------------------------
  logic main_active;
  logic sub_active;
  logic main_fail;
  logic sub_fail;

  assign main_active = main_fail_monitor_enable & main_osc_ready;
  assign sub_active  = sub_fail_monitor_enable & sub_osc_ready;

  cfm_fail_watch u_main_watch (
    .mclk       (mclk),
    .rst        (rst),
    .active     (main_active),
    .ref_edge   (hcr_edge),
    .watch_edge (main_edge),
    .fail       (main_fail)
  );

  cfm_fail_watch u_sub_watch (
    .mclk       (mclk),
    .rst        (rst),
    .active     (sub_active),
    .ref_edge   (lcr_edge),
    .watch_edge (sub_edge),
    .fail       (sub_fail)
  );

  // ----------------------------------------
  // Failure flags and reset request
  // ----------------------------------------
  logic next_main_fail_flag;
  logic next_sub_fail_flag;
  logic next_fail_reset_req;

  // A failure in the clearing cycle wins over the clear
  always_comb begin
    next_main_fail_flag = main_fail | (main_fail_flag & ~fail_flag_clear);
    next_sub_fail_flag  = sub_fail | (sub_fail_flag & ~fail_flag_clear);
    // Request holds until the system reset it asks for arrives
    next_fail_reset_req = fail_reset_req | main_fail | sub_fail;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      main_fail_flag <= 1'b0;
      sub_fail_flag  <= 1'b0;
      fail_reset_req <= 1'b0;
    end else begin
      main_fail_flag <= next_main_fail_flag;
      sub_fail_flag  <= next_sub_fail_flag;
      fail_reset_req <= next_fail_reset_req;
    end
  end

  // ----------------------------------------
  // Settings held while the check runs
  // ----------------------------------------
  logic                    check_run;
  logic [2:0]              ccs_held;
  logic [2:0]              next_ccs_held;
  logic                    reset_en_held;
  logic                    next_reset_en_held;
  logic [`CFM_COUNT_W-1:0] upper_held;
  logic [`CFM_COUNT_W-1:0] next_upper_held;
  logic [`CFM_COUNT_W-1:0] lower_held;
  logic [`CFM_COUNT_W-1:0] next_lower_held;

  assign check_run = freq_check_enable & main_osc_ready;

  // Settings are taken while the check is off, so a careless write
  // during a measurement cannot tear a comparison
  always_comb begin
    next_ccs_held      = ccs_held;
    next_reset_en_held = reset_en_held;
    next_upper_held    = upper_held;
    next_lower_held    = lower_held;
    if (!freq_check_enable) begin
      next_ccs_held      = count_cycle_select;
      next_reset_en_held = freq_reset_enable;
      next_upper_held    = window_upper_reg;
      next_lower_held    = window_lower_reg;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ccs_held      <= `CFM_CCS_RESET;
      reset_en_held <= 1'b0;
      upper_held    <= `CFM_UPPER_RESET;
      lower_held    <= `CFM_LOWER_RESET;
    end else begin
      ccs_held      <= next_ccs_held;
      reset_en_held <= next_reset_en_held;
      upper_held    <= next_upper_held;
      lower_held    <= next_lower_held;
    end
  end

  // ----------------------------------------
  // High-speed CR divider
  // ----------------------------------------
  logic [`CFM_DIV_W-1:0] div_count;
  logic [`CFM_DIV_W-1:0] next_div_count;
  logic                  div_tap;
  logic                  div_tap_last;
  logic                  div_edge;

  // Divider advances on synchronised CR edges, so its output is
  // already in the mclk domain
  always_comb begin
    next_div_count = div_count;
    if (!check_run) begin
      next_div_count = '0;
    end else if (hcr_edge) begin
      next_div_count = div_count + 10'h001;
    end
  end

  // ratio select
  // Prohibited codes fall back to the slowest ratio
  always_comb begin
    case (ccs_held)
      `CFM_CCS_DIV256: div_tap = div_count[`CFM_DIV256_BIT];
      `CFM_CCS_DIV512: div_tap = div_count[`CFM_DIV512_BIT];
      default:         div_tap = div_count[`CFM_DIV1024_BIT];
    endcase
  end

  assign div_edge = div_tap & ~div_tap_last;

  always_ff @(posedge mclk) begin
    if (rst) begin
      div_count    <= '0;
      div_tap_last <= 1'b0;
    end else begin
      div_count    <= next_div_count;
      div_tap_last <= div_tap;
    end
  end

  // ----------------------------------------
  // Frequency window check
  // ----------------------------------------
  cfm_freq_state_type      fstate;
  cfm_freq_state_type      next_fstate;
  logic [`CFM_COUNT_W-1:0] next_live_count;
  logic [`CFM_COUNT_W-1:0] next_captured_count_reg;
  logic                    next_freq_irq_req;
  logic                    next_freq_reset_req;
  logic                    out_of_window;
  logic                    freq_err;

  assign out_of_window = (live_count < lower_held) || (live_count > upper_held);

  always_comb begin
    next_fstate             = fstate;
    next_live_count         = live_count;
    next_captured_count_reg = captured_count_reg;
    freq_err                = 1'b0;
    case (fstate)
      cfm_fs_idle: begin
        next_live_count = '0;
        if (check_run) begin
          next_fstate = cfm_fs_arm;
        end
      end
      cfm_fs_arm: begin
        // First divided edge only opens the first interval
        next_live_count = '0;
        if (!check_run) begin
          next_fstate = cfm_fs_idle;
        end else if (div_edge) begin
          next_fstate = cfm_fs_measure;
        end
      end
      cfm_fs_measure: begin
        if (!check_run) begin
          next_fstate     = cfm_fs_idle;
          next_live_count = '0;
        end else if (div_edge) begin
          next_live_count = '0;
          if (out_of_window) begin
            freq_err = 1'b1;
            next_captured_count_reg = live_count;
          end
        end else if (main_edge && live_count != 16'hFFFF) begin
          next_live_count = live_count + 16'h0001;
        end
      end
      default: begin
        next_fstate     = cfm_fs_idle;
        next_live_count = '0;
      end
    endcase
  end

  // Interrupt and reset request
  always_comb begin
    next_freq_irq_req   = freq_err | (freq_irq_req & ~freq_irq_clear);
    next_freq_reset_req = freq_reset_req;
    if (freq_err && freq_irq_req && reset_en_held) begin
      next_freq_reset_req = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      fstate             <= cfm_fs_idle;
      live_count         <= '0;
      captured_count_reg <= `CFM_CAPTURE_RESET;
      freq_irq_req       <= 1'b0;
      freq_reset_req     <= 1'b0;
    end else begin
      fstate             <= next_fstate;
      live_count         <= next_live_count;
      captured_count_reg <= next_captured_count_reg;
      freq_irq_req       <= next_freq_irq_req;
      freq_reset_req     <= next_freq_reset_req;
    end
  end

endmodule

/* File: tb/cfm_top_checker.sv */
// Assertions and covers for the clock supervisor top.
// Assumes it is bound to cfm_top and sees only that module's ports.
module cfm_top_checker (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        main_osc_ready,
  input wire logic        sub_osc_ready,
  input wire logic        main_fail_monitor_enable,
  input wire logic        sub_fail_monitor_enable,
  input wire logic        freq_check_enable,
  input wire logic        freq_reset_enable,
  input wire logic [15:0] window_upper_reg,
  input wire logic [15:0] window_lower_reg,
  input wire logic        freq_irq_clear,
  input wire logic        main_fail_flag,
  input wire logic        sub_fail_flag,
  input wire logic        fail_reset_req,
  input wire logic        freq_irq_req,
  input wire logic        freq_reset_req,
  input wire logic [15:0] captured_count_reg
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------
  // Checks
  // ------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Only a reset may take a failure request away
  a_fail_req_hold: assert property (fail_reset_req |=> fail_reset_req)
    else $error("fail reset request dropped");
  a_main_fail_cause: assert property ($rose(main_fail_flag) |->
    fail_reset_req && $past(main_fail_monitor_enable) && $past(main_osc_ready))
    else $error("main failure without an armed watch");
  a_sub_fail_cause: assert property ($rose(sub_fail_flag) |->
    fail_reset_req && $past(sub_fail_monitor_enable) && $past(sub_osc_ready))
    else $error("sub failure without an armed watch");
  a_freq_reset_cause: assert property ($rose(freq_reset_req) |->
    $past(freq_irq_req) && $past(freq_reset_enable))
    else $error("frequency reset without pending interrupt");
  a_irq_hold: assert property (freq_irq_req && !freq_irq_clear |=> freq_irq_req)
    else $error("frequency interrupt dropped without clear");
  a_irq_enabled: assert property ($rose(freq_irq_req) |-> $past(freq_check_enable))
    else $error("frequency interrupt while check disabled");
  a_irq_out_window: assert property ($rose(freq_irq_req) |->
    captured_count_reg < window_lower_reg || captured_count_reg > window_upper_reg)
    else $error("interrupt with captured count inside window");
  // Captured count moves only together with a raised interrupt
  a_capture_cause: assert property ($changed(captured_count_reg) |-> freq_irq_req)
    else $error("captured count changed without error");
  c_main_fail: cover property ($rose(main_fail_flag));
  c_sub_fail: cover property ($rose(sub_fail_flag));
  c_freq_irq: cover property ($rose(freq_irq_req));
  c_freq_reset: cover property ($rose(freq_reset_req));
endmodule

bind cfm_top cfm_top_checker i_cfm_top_checker (.*);

/* File: tb/cfm_osc_model.sv */
// Oscillators seen at the supervisor pins: main, sub and both CR clocks.
// Assumes the bench drives the run inputs; a stopped clock stands low.
module cfm_osc_model #(
  parameter int MAIN_HALF = 160,
  parameter int SUB_HALF  = 1000,
  parameter int HCR_HALF  = 200,
  parameter int LCR_HALF  = 500
) (
  input  wire logic main_run,
  input  wire logic sub_run,
  output logic      main_clk_pin,
  output logic      sub_clk_pin,
  output logic      hcr_clk_pin,
  output logic      lcr_clk_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------
  // Clocks
  // ------
  initial begin
    {main_clk_pin, sub_clk_pin, hcr_clk_pin, lcr_clk_pin} = 4'h0;
  end
  // CR clocks run free; half periods avoid the mclk rising edge
  always #(HCR_HALF) hcr_clk_pin = ~hcr_clk_pin;
  // Low-speed CR starts half a half-period late: on a whole multiple its
  // edges would land on the mclk rising edge and race the synchroniser
  initial begin
    #(LCR_HALF / 2);
    forever #(LCR_HALF) lcr_clk_pin = ~lcr_clk_pin;
  end
  // A failed oscillator gives no more edges
  always #(MAIN_HALF) main_clk_pin = main_run ? ~main_clk_pin : 1'b0;
  always #(SUB_HALF) sub_clk_pin = sub_run ? ~sub_clk_pin : 1'b0;
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the clock supervisor top.
// Assumes the oscillator model feeds the pins; the bench drives the rest.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, rst, main_run, sub_run, main_osc_ready, sub_osc_ready;
  logic        main_fail_monitor_enable, sub_fail_monitor_enable;
  logic        freq_check_enable, freq_reset_enable, fail_flag_clear, freq_irq_clear;
  logic        main_clk_pin, sub_clk_pin, hcr_clk_pin, lcr_clk_pin;
  logic        main_fail_flag, sub_fail_flag, fail_reset_req;
  logic        freq_irq_req, freq_reset_req;
  logic [2:0]  count_cycle_select;
  logic [15:0] window_upper_reg, window_lower_reg, captured_count_reg, live_count, exp;
  int          n_mismatch, cmp_count, i;
  cfm_osc_model i_cfm_osc_model (.*);
  cfm_top i_cfm_top (.*);
  // -------
  // Helpers
  // -------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
    cmp_count++;
    if (seen !== want) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic check_bit(input string what, input logic seen, input logic want);
    check(what, {15'h0000, seen}, {15'h0000, want});
  endtask
  // Counts jitter by a cycle or two through the pin synchronisers
  function automatic logic near(input logic [15:0] a, input logic [15:0] b);
    return (a + 16'h0002 >= b) && (a <= b + 16'h0002);
  endfunction
  // Waits end at a falling edge so outputs are settled when looked at
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic reset_dut();
    @(posedge mclk);
    rst <= 1'b1;
    tick(12);
    @(posedge mclk);
    rst <= 1'b0;
    tick(2);
  endtask
  // Settings change only with the check off; pending interrupt cleared
  task automatic start_freq(input logic [2:0] code, input logic [15:0] lo, input logic [15:0] hi,
                            input logic re);
    @(posedge mclk);
    freq_check_enable <= 1'b0;
    repeat (4) @(posedge mclk);
    freq_irq_clear <= 1'b1;
    count_cycle_select <= code;
    window_lower_reg <= lo;
    window_upper_reg <= hi;
    freq_reset_enable <= re;
    @(posedge mclk);
    freq_irq_clear <= 1'b0;
    repeat (2) @(posedge mclk);
    freq_check_enable <= 1'b1;
    tick(1);
  endtask
  task automatic wait_irq(input int n);
    for (int k = 0; k < n && freq_irq_req !== 1'b1; k++) @(negedge mclk);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Watchdog sized a little above the longest expected run
  initial begin
    #3600000;
    n_mismatch++;
    test_done();
  end
  // -----
  // Tests
  // -----
  initial begin
    {rst, main_run, sub_run, main_osc_ready, sub_osc_ready} = 5'h1f;
    {main_fail_monitor_enable, sub_fail_monitor_enable} = 2'h3;
    {freq_check_enable, freq_reset_enable, fail_flag_clear, freq_irq_clear} = 4'h0;
    count_cycle_select = 3'h7;
    window_lower_reg = 16'h0000;
    window_upper_reg = 16'hFFFF;
    n_mismatch = 0;
    cmp_count = 0;
    tick(12);
    @(posedge mclk);
    rst <= 1'b0;
    tick(1000);
    check_bit("fail_req_healthy", fail_reset_req, 1'b0);
    @(posedge mclk);
    main_fail_monitor_enable <= 1'b0;
    main_run <= 1'b0;
    tick(600);
    check_bit("fail_req_disabled", fail_reset_req, 1'b0);
    @(posedge mclk);
    main_fail_monitor_enable <= 1'b1;
    main_osc_ready <= 1'b0;
    tick(600);
    check_bit("fail_req_stabilising", fail_reset_req, 1'b0);
    @(posedge mclk);
    main_osc_ready <= 1'b1;
    tick(280);
    check_bit("main_flag_early", main_fail_flag, 1'b0);
    tick(80);
    check_bit("main_flag", main_fail_flag, 1'b1);
    check_bit("sub_flag_quiet", sub_fail_flag, 1'b0);
    check_bit("fail_req_main", fail_reset_req, 1'b1);
    @(posedge mclk);
    main_run <= 1'b1;
    repeat (20) @(posedge mclk);
    fail_flag_clear <= 1'b1;
    @(posedge mclk);
    fail_flag_clear <= 1'b0;
    tick(2);
    check_bit("main_flag_cleared", main_fail_flag, 1'b0);
    check_bit("fail_req_held", fail_reset_req, 1'b1);
    $display("test main failure watch done");
    reset_dut();
    @(posedge mclk);
    sub_run <= 1'b0;
    tick(700);
    check_bit("sub_flag_early", sub_fail_flag, 1'b0);
    tick(150);
    check_bit("sub_flag", sub_fail_flag, 1'b1);
    check_bit("main_flag_quiet", main_fail_flag, 1'b0);
    check_bit("fail_req_sub", fail_reset_req, 1'b1);
    @(posedge mclk);
    sub_run <= 1'b1;
    $display("test sub failure watch done");
    reset_dut();
    @(posedge mclk);
    window_upper_reg <= 16'h0001;
    tick(5300);
    check_bit("irq_disabled", freq_irq_req, 1'b0);
    check("count_idle", live_count, 16'h0000);
    @(posedge mclk);
    main_osc_ready <= 1'b0;
    start_freq(3'h5, 16'h0000, 16'h0001, 1'b0);
    tick(5300);
    check_bit("irq_stabilising", freq_irq_req, 1'b0);
    @(posedge mclk);
    main_osc_ready <= 1'b1;
    $display("test window check held off done");
    for (i = 0; i < 3; i++) begin
      exp = 16'h0140 << i;
      start_freq(3'h5 + 3'(i), 16'h0000, exp - 16'h0008, 1'b0);
      check_bit("irq_cleared", freq_irq_req, 1'b0);
      wait_irq(3 * (2560 << i) + 100);
      check_bit("irq_above", freq_irq_req, 1'b1);
      check_bit("captured_near", near(captured_count_reg, exp), 1'b1);
      $display("test count cycle code %0d done", i + 5);
    end
    start_freq(3'h5, 16'h013D, 16'h0143, 1'b0);
    tick(5300);
    check_bit("irq_inside", freq_irq_req, 1'b0);
    check_bit("count_running", live_count != 16'h0000, 1'b1);
    start_freq(3'h5, 16'h014A, 16'hFFFF, 1'b0);
    wait_irq(5300);
    check_bit("irq_below", freq_irq_req, 1'b1);
    check_bit("captured_below", near(captured_count_reg, 16'h0140), 1'b1);
    $display("test window bounds done");
    start_freq(3'h5, 16'h0000, 16'h012C, 1'b1);
    wait_irq(5300);
    check_bit("freq_reset_first", freq_reset_req, 1'b0);
    tick(2700);
    check_bit("freq_reset_second", freq_reset_req, 1'b1);
    reset_dut();
    start_freq(3'h5, 16'h0000, 16'h012C, 1'b0);
    tick(7800);
    check_bit("irq_masked_run", freq_irq_req, 1'b1);
    check_bit("freq_reset_masked", freq_reset_req, 1'b0);
    $display("test frequency reset done");
    test_done();
  end
endmodule
